//--- logic/dsw_builder.sv
// Purpose: assemble the 16-bit drive status word for each drive telegram
// Assumes: cycle_strobe pulses once per communication cycle on mclk
// Notes: master handshake arrives from link logic on mclk, no synchroniser needed
`timescale 1ns/10ps
module dsw_builder
(
   input wire logic mclk,
   input wire logic reset,
   input wire logic cycle_strobe,
   input wire dsw_pkg::dsw_cond_t cond,
   input wire logic master_handshake_bit,
   input wire dsw_pkg::dsw_svc_t svc,
   output logic [15:0] status_word_r,
   output logic step_start_r
);

   ////////////////////////////////////////////////////////////////////////
   // service channel step tracking

   logic master_seen_r;
   logic busy_r;
   logic busy_nxt;
   logic drive_handshake_bit_r;
   logic hs_nxt;
   logic err_r;
   logic err_nxt;
   wire new_step = (master_handshake_bit != master_seen_r) && !busy_r;
   wire finish = busy_r && svc.step_done;

   // a toggle on the master side opens a step; done closes it and echoes the toggle
   assign busy_nxt = new_step ? 1'b1 : (finish ? 1'b0 : busy_r);
   assign hs_nxt = finish ? master_seen_r : drive_handshake_bit_r;
   // error latches with the finished step and is dropped by the next step
   assign err_nxt = finish ? svc.step_error : (new_step ? 1'b0 : err_r);

   // toggles during busy are held off until the step closes; the master must not issue them
   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         master_seen_r <= 1'b0;
         busy_r <= 1'b0;
         drive_handshake_bit_r <= 1'b0;
         err_r <= 1'b0;
         step_start_r <= 1'b0;
      end
      else
      begin
         if (new_step)
            master_seen_r <= master_handshake_bit;
         busy_r <= busy_nxt;
         drive_handshake_bit_r <= hs_nxt;
         err_r <= err_nxt;
         step_start_r <= new_step;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // word assembly

   logic [15:0] word_nxt;
   assign word_nxt[dsw_pkg::RDY_HI:dsw_pkg::RDY_LO] = cond.ready;
   assign word_nxt[dsw_pkg::SHUTDOWN_B] = cond.class1_shutdown;
   assign word_nxt[dsw_pkg::C2_CHG_B] = cond.class2_changed;
   assign word_nxt[dsw_pkg::C3_CHG_B] = cond.class3_changed;
   assign word_nxt[dsw_pkg::MODE_HI:dsw_pkg::MODE_LO] = cond.op_mode;
   assign word_nxt[dsw_pkg::RT2_B] = cond.rt_status_two;
   assign word_nxt[dsw_pkg::RT1_B] = cond.rt_status_one;
   assign word_nxt[dsw_pkg::PROC_CHG_B] = cond.proc_ack_changing;
   assign word_nxt[dsw_pkg::PARAM_B] = cond.param_level_one | cond.param_level_two;
   assign word_nxt[dsw_pkg::CMD_FOLLOW_B] = cond.cmd_following;
   assign word_nxt[dsw_pkg::SVC_ERR_B] = err_nxt;
   assign word_nxt[dsw_pkg::SVC_BUSY_B] = busy_nxt;
   assign word_nxt[dsw_pkg::HS_B] = hs_nxt;

   // latched only on the cycle strobe so the telegram sees one stable word per cycle
   always_ff @(posedge mclk)
   begin
      if (reset)
         status_word_r <= dsw_pkg::DSW_RESET;
      else if (cycle_strobe)
         status_word_r <= word_nxt;
   end

   ////////////////////////////////////////////////////////////////////////
   // checks

   // a fresh toggle from the master while the channel is free
   sequence step_open_s;
      !busy_r && (master_handshake_bit != master_seen_r);
   endsequence

   // the step closes on a done pulse while busy
   sequence step_close_s;
      busy_r && svc.step_done;
   endsequence

   // a closing step that reports a failure
   sequence step_fail_s;
      busy_r && svc.step_done && svc.step_error;
   endsequence

   // a closing step that reports success
   sequence step_pass_s;
      busy_r && svc.step_done && !svc.step_error;
   endsequence

   // busy and still waiting for the step processor
   sequence step_wait_s;
      busy_r && !svc.step_done;
   endsequence

   // idle with the master's last toggle already taken
   sequence step_quiet_s;
      !busy_r && (master_handshake_bit == master_seen_r);
   endsequence

   busy_sets_a: assert property (@(posedge mclk) disable iff (reset)
      step_open_s |=> busy_r && step_start_r)
      else $error("busy not raised on new step");
   hs_echo_a: assert property (@(posedge mclk) disable iff (reset)
      busy_r && svc.step_done |=> !busy_r && (drive_handshake_bit_r == master_seen_r))
      else $error("handshake not echoed at step end");
   hs_stable_a: assert property (@(posedge mclk) disable iff (reset)
      busy_r |=> $stable(drive_handshake_bit_r) || $fell(busy_r))
      else $error("handshake moved while busy");

   ////////////////////////////////////////////////////////////////////////
   // service channel checks, one step phase at a time

   // busy stays up until the step processor reports done
   busy_holds_a: assert property (@(posedge mclk) disable iff (reset)
      step_wait_s |=> busy_r)
      else $error("busy dropped before step done");
   busy_clears_a: assert property (@(posedge mclk) disable iff (reset)
      step_close_s |=> !busy_r)
      else $error("busy not cleared at step end");

   // a toggle that lands while busy is not taken until busy clears, then opens the next step
   toggle_refused_a: assert property (@(posedge mclk) disable iff (reset)
      busy_r && (master_handshake_bit != master_seen_r)
         |=> !step_start_r && $stable(master_seen_r))
      else $error("toggle taken while busy");
   no_toggle_a: assert property (@(posedge mclk) disable iff (reset)
      step_quiet_s |=> !step_start_r && !busy_r)
      else $error("step opened without a toggle");

   // the start pulse marks acceptance and lasts exactly one cycle
   start_busy_a: assert property (@(posedge mclk) disable iff (reset)
      step_start_r |-> busy_r)
      else $error("start pulse without busy");
   start_pulse_a: assert property (@(posedge mclk) disable iff (reset)
      step_start_r |=> !step_start_r)
      else $error("start pulse longer than one cycle");

   // the master level is copied only when a step is taken
   seen_capture_a: assert property (@(posedge mclk) disable iff (reset)
      step_open_s |=> master_seen_r == $past(master_handshake_bit))
      else $error("master level not captured");
   seen_holds_a: assert property (@(posedge mclk) disable iff (reset)
      busy_r || (master_handshake_bit == master_seen_r) |=> $stable(master_seen_r))
      else $error("master copy moved outside acceptance");

   // the drive handshake only moves on the edge that closes a step
   hs_idle_a: assert property (@(posedge mclk) disable iff (reset)
      !busy_r |=> $stable(drive_handshake_bit_r))
      else $error("handshake moved while idle");
   hs_moves_a: assert property (@(posedge mclk) disable iff (reset)
      step_close_s ##0 (drive_handshake_bit_r != master_seen_r) |=> $changed(drive_handshake_bit_r))
      else $error("handshake did not toggle at step end");
   step_round_a: assert property (@(posedge mclk) disable iff (reset)
      step_open_s ##1 step_close_s
         |=> !busy_r && !step_start_r
            && (drive_handshake_bit_r == $past(master_handshake_bit, 2)))
      else $error("handshake not echoed after a short step");

   // the error bit follows the closing report and is dropped by the next step
   err_set_a: assert property (@(posedge mclk) disable iff (reset)
      step_fail_s |=> err_r)
      else $error("error not latched at step end");
   err_clean_a: assert property (@(posedge mclk) disable iff (reset)
      step_pass_s |=> !err_r)
      else $error("error set after a clean step");
   err_drop_a: assert property (@(posedge mclk) disable iff (reset)
      step_open_s |=> !err_r)
      else $error("error kept into a new step");
   err_busy_hold_a: assert property (@(posedge mclk) disable iff (reset)
      step_wait_s |=> $stable(err_r))
      else $error("error moved during a step");
   err_idle_hold_a: assert property (@(posedge mclk) disable iff (reset)
      step_quiet_s |=> $stable(err_r))
      else $error("error moved while idle");

   // a done pulse while idle has no step to close
   idle_done_a: assert property (@(posedge mclk) disable iff (reset)
      !busy_r && svc.step_done && (master_handshake_bit == master_seen_r)
         |=> !busy_r && $stable(err_r) && $stable(drive_handshake_bit_r))
      else $error("done pulse acted while idle");

   ////////////////////////////////////////////////////////////////////////
   // status word checks: each field against what the strobe edge saw

   // readiness, shutdown and diagnostic change flags
   ready_bits_a: assert property (@(posedge mclk) disable iff (reset)
      cycle_strobe |=> status_word_r[dsw_pkg::RDY_HI:dsw_pkg::RDY_LO] == $past(cond.ready))
      else $error("ready bits wrong");
   shutdown_bit_a: assert property (@(posedge mclk) disable iff (reset)
      cycle_strobe |=> status_word_r[dsw_pkg::SHUTDOWN_B] == $past(cond.class1_shutdown))
      else $error("shutdown bit wrong");
   c2_bit_a: assert property (@(posedge mclk) disable iff (reset)
      cycle_strobe |=> status_word_r[dsw_pkg::C2_CHG_B] == $past(cond.class2_changed))
      else $error("class two change bit wrong");
   c3_bit_a: assert property (@(posedge mclk) disable iff (reset)
      cycle_strobe |=> status_word_r[dsw_pkg::C3_CHG_B] == $past(cond.class3_changed))
      else $error("class three change bit wrong");
   diag_bits_a: assert property (@(posedge mclk) disable iff (reset)
      cycle_strobe |=> status_word_r[dsw_pkg::C2_CHG_B:dsw_pkg::C3_CHG_B]
         == {$past(cond.class2_changed), $past(cond.class3_changed)})
      else $error("diagnostic change bits wrong");

   // operation mode and the two real-time status signals
   mode_bits_a: assert property (@(posedge mclk) disable iff (reset)
      cycle_strobe |=> status_word_r[dsw_pkg::MODE_HI:dsw_pkg::MODE_LO] == $past(cond.op_mode))
      else $error("mode bits wrong");
   rt_two_a: assert property (@(posedge mclk) disable iff (reset)
      cycle_strobe |=> status_word_r[dsw_pkg::RT2_B] == $past(cond.rt_status_two))
      else $error("real-time bit two wrong");
   rt_one_a: assert property (@(posedge mclk) disable iff (reset)
      cycle_strobe |=> status_word_r[dsw_pkg::RT1_B] == $past(cond.rt_status_one))
      else $error("real-time bit one wrong");
   rt_bits_a: assert property (@(posedge mclk) disable iff (reset)
      cycle_strobe |=> status_word_r[dsw_pkg::RT2_B:dsw_pkg::RT1_B]
         == {$past(cond.rt_status_two), $past(cond.rt_status_one)})
      else $error("real-time bits wrong");

   // procedure change, parameterization and command value processing
   proc_bit_a: assert property (@(posedge mclk) disable iff (reset)
      cycle_strobe |=> status_word_r[dsw_pkg::PROC_CHG_B] == $past(cond.proc_ack_changing))
      else $error("procedure change bit wrong");
   param_bit_a: assert property (@(posedge mclk) disable iff (reset)
      cycle_strobe |=> status_word_r[dsw_pkg::PARAM_B]
         == ($past(cond.param_level_one) | $past(cond.param_level_two)))
      else $error("param level bit wrong");
   param_one_a: assert property (@(posedge mclk) disable iff (reset)
      cycle_strobe && cond.param_level_one |=> status_word_r[dsw_pkg::PARAM_B])
      else $error("level one not reported");
   param_two_a: assert property (@(posedge mclk) disable iff (reset)
      cycle_strobe && cond.param_level_two |=> status_word_r[dsw_pkg::PARAM_B])
      else $error("level two not reported");
   param_none_a: assert property (@(posedge mclk) disable iff (reset)
      cycle_strobe && !cond.param_level_one && !cond.param_level_two
         |=> !status_word_r[dsw_pkg::PARAM_B])
      else $error("param bit set with no level active");
   follow_bit_a: assert property (@(posedge mclk) disable iff (reset)
      cycle_strobe |=> status_word_r[dsw_pkg::CMD_FOLLOW_B] == $past(cond.cmd_following))
      else $error("command follow bit wrong");

   // service bits come from next-state values, so a change on the strobe shows at once
   svc_bits_a: assert property (@(posedge mclk) disable iff (reset)
      cycle_strobe |=> status_word_r[dsw_pkg::SVC_ERR_B:dsw_pkg::HS_B]
         == {err_r, busy_r, drive_handshake_bit_r})
      else $error("service bits differ from state");
   busy_word_a: assert property (@(posedge mclk) disable iff (reset)
      cycle_strobe && !busy_r && (master_handshake_bit != master_seen_r)
         |=> status_word_r[dsw_pkg::SVC_BUSY_B] && !status_word_r[dsw_pkg::SVC_ERR_B])
      else $error("accepted step not shown busy");
   echo_word_a: assert property (@(posedge mclk) disable iff (reset)
      cycle_strobe && busy_r && svc.step_done
         |=> !status_word_r[dsw_pkg::SVC_BUSY_B] && (status_word_r[dsw_pkg::HS_B] == master_seen_r))
      else $error("echo not shown in word");
   err_word_a: assert property (@(posedge mclk) disable iff (reset)
      cycle_strobe && busy_r && svc.step_done
         |=> status_word_r[dsw_pkg::SVC_ERR_B] == $past(svc.step_error))
      else $error("error report not shown in word");

   // without a strobe the telegram keeps the word of the last cycle
   word_hold_a: assert property (@(posedge mclk) disable iff (reset)
      !cycle_strobe |=> $stable(status_word_r))
      else $error("word changed without strobe");

   ////////////////////////////////////////////////////////////////////////
   // reset values, checked without the reset disable

   reset_clear_a: assert property (@(posedge mclk)
      reset |=> (status_word_r == dsw_pkg::DSW_RESET) && !step_start_r)
      else $error("outputs not cleared by reset");
   reset_state_a: assert property (@(posedge mclk)
      reset |=> !busy_r && !err_r && !drive_handshake_bit_r && !master_seen_r)
      else $error("step state not cleared by reset");
endmodule

//--- logic/dsw_pkg.sv
// Purpose: shared constants and carriers for the drive status word builder
// Assumes: one status word is latched per communication cycle
// Notes: bit positions follow the status word layout
package dsw_pkg;
   localparam int unsigned DSW_W = 16;
   localparam int unsigned RDY_HI = 15;
   localparam int unsigned RDY_LO = 14;
   localparam int unsigned SHUTDOWN_B = 13;
   localparam int unsigned C2_CHG_B = 12;
   localparam int unsigned C3_CHG_B = 11;
   localparam int unsigned MODE_HI = 10;
   localparam int unsigned MODE_LO = 8;
   localparam int unsigned RT2_B = 7;
   localparam int unsigned RT1_B = 6;
   localparam int unsigned PROC_CHG_B = 5;
   localparam int unsigned PARAM_B = 4;
   localparam int unsigned CMD_FOLLOW_B = 3;
   localparam int unsigned SVC_ERR_B = 2;
   localparam int unsigned SVC_BUSY_B = 1;
   localparam int unsigned HS_B = 0;
   localparam logic [15:0] DSW_RESET = 16'h0000;

   typedef enum logic [1:0] {DSW_NOT_READY, DSW_LOGIC_READY, DSW_POWERED, DSW_ENABLED}
      dsw_ready_t;

   // drive-side condition inputs sampled once per cycle
   typedef struct packed {
      dsw_ready_t ready;
      logic class1_shutdown;
      logic class2_changed;
      logic class3_changed;
      logic [2:0] op_mode;
      logic rt_status_two;
      logic rt_status_one;
      logic proc_ack_changing;
      logic param_level_one;
      logic param_level_two;
      logic cmd_following;
   } dsw_cond_t;

   // service channel step interface from the drive's step processor
   typedef struct packed {
      logic step_done;
      logic step_error;
   } dsw_svc_t;
endpackage

//--- tb/dsw_master_model.sv
// Purpose: master side model that paces service steps by handshake
// Assumes: go asks for one step and the status word refreshes each cycle
// Notes: a step asked for while the drive is busy is not sent
`timescale 1ns/10ps
module dsw_master_model
(
   input wire logic mclk,
   input wire logic reset,
   input wire logic go,
   input wire logic [15:0] status_word,
   output logic master_handshake_bit
);
   logic idle;
   // only start once busy is clear and our handshake has been echoed
   assign idle = !status_word[1] && (status_word[0] == master_handshake_bit);
   ////////////////////////////////////////
   // toggle just after the edge so the builder sees a settled level
   always @(posedge mclk)
   begin
      if (reset)
         master_handshake_bit <= 1'b0;
      else if (go && idle)
         master_handshake_bit <= ~master_handshake_bit;
   end
endmodule

//--- tb/testbench.sv
// Purpose: self-checking bench for the drive status word builder
// Assumes: strobe held high, except for the one hold check, so the word refreshes each cycle
// Notes: inputs change and checks run on the falling edge
`timescale 1ns/10ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin error_cnt++; $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module testbench;
   logic mclk = 1'b0;
   logic reset = 1'b1;
   logic cycle_strobe = 1'b1;
   logic go = 1'b0;
   logic master_handshake_bit;
   logic step_start_r;
   logic [15:0] status_word_r;
   logic [15:0] exp_w;
   logic [2:0] i;
   dsw_pkg::dsw_cond_t cond = '0;
   dsw_pkg::dsw_svc_t svc = '0;
   int error_cnt = 0;
   int tests_run = 0;
   int cycles = 0;
   always #25 mclk = ~mclk;
   dsw_builder dut (.mclk(mclk), .reset(reset), .cycle_strobe(cycle_strobe), .cond(cond),
      .master_handshake_bit(master_handshake_bit), .svc(svc),
      .status_word_r(status_word_r), .step_start_r(step_start_r));
   dsw_master_model master (.mclk(mclk), .reset(reset), .go(go),
      .status_word(status_word_r), .master_handshake_bit(master_handshake_bit));
   ////////////////////////////////////////
   task automatic tally_and_finish();
      if (error_cnt == 0 && tests_run > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // the whole run needs well under 100 cycles, so a hang shows quickly
   always @(posedge mclk)
   begin
      cycles++;
      if (cycles == 400)
      begin
         error_cnt++;
         tally_and_finish();
      end
   end
   // one service step: request, accept, finish; low bits checked twice
   task automatic step(input logic err, input logic [2:0] busy_w, input logic [2:0] done_w);
      @(negedge mclk) go = 1'b1;
      @(negedge mclk) go = 1'b0;
      @(negedge mclk);
      `CHK(step_start_r, 1'b1)
      `CHK(status_word_r[2:0], busy_w)
      svc = '{step_done: 1'b1, step_error: err};
      @(negedge mclk) svc = '0;
      `CHK(step_start_r, 1'b0)
      `CHK(status_word_r[2:0], done_w)
   endtask
   ////////////////////////////////////////
   initial
   begin
      repeat (4) @(negedge mclk);
      reset = 1'b0;
      `CHK(status_word_r, 16'h0000)
      // every mode code and readiness code, each flag both ways
      for (int n = 0; n < 8; n++)
      begin
         i = n[2:0];
         cond = {i[1:0], i[0], i[1], i[2], i, i[0], ~i[0], i[1], i[0], i[1], i[2]};
         exp_w = {i[1:0], i[0], i[1], i[2], i, i[0], ~i[0], i[1], i[0] | i[1], i[2], 3'b000};
         @(negedge mclk);
         `CHK(status_word_r, exp_w)
      end
      // without a strobe the word must hold its last value
      cycle_strobe = 1'b0;
      cond = '0;
      @(negedge mclk);
      `CHK(status_word_r, exp_w)
      cycle_strobe = 1'b1;
      step(1'b1, 3'b010, 3'b101);
      step(1'b0, 3'b011, 3'b000);
      // a completion while idle must not raise the error bit
      @(negedge mclk) svc = '{step_done: 1'b1, step_error: 1'b1};
      @(negedge mclk) svc = '0;
      @(negedge mclk);
      `CHK(status_word_r[2:0], 3'b000)
      // reset in mid-step drops busy and both handshake copies
      @(negedge mclk) go = 1'b1;
      @(negedge mclk) go = 1'b0;
      @(negedge mclk);
      `CHK(status_word_r[2:0], 3'b010)
      reset = 1'b1;
      @(negedge mclk) reset = 1'b0;
      `CHK(status_word_r, 16'h0000)
      `CHK(step_start_r, 1'b0)
      step(1'b0, 3'b010, 3'b001);
      tally_and_finish();
   end
endmodule
